//--- pkg/rwd_pkg.sv
package rwd_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [9:0]  IDX_MODE      = 10'h300;
  localparam logic [9:0]  IDX_CMD       = 10'h301;
  localparam logic [9:0]  IDX_IRQ_STAT  = 10'h302;
  localparam logic [9:0]  IDX_IRQ_MASK  = 10'h303;
  localparam logic [9:0]  IDX_CNT_STAT  = 10'h304;
  // Mode register fields and value after reset
  localparam int          MODE_EN_BIT   = 7;
  localparam int          MODE_PER_LSB  = 5;
  localparam int          MODE_I2_BIT   = 2;
  localparam int          MODE_RST_BIT  = 1;
  localparam logic        EN_RESET      = 1'h1;
  localparam logic [1:0]  PER_RESET     = 2'h0;
  // Command codes
  localparam logic [7:0]  CMD_CLEAR     = 8'h4e;
  localparam logic [7:0]  CMD_DISABLE   = 8'hb1;
  // Counter and reset pulse
  localparam int          CNT_W         = 22;
  localparam logic [4:0]  RST_STATES    = 5'h16;
  // Interrupt status bits
  localparam int          IRQ_EXPIRE    = 0;
  localparam int          IRQ_WRESET    = 1;
  // Counter status fields
  localparam int          CST_ACTIVE    = 24;
  localparam int          CST_COUNTING  = 25;
  // Bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Address decode shared by the bus slave for both directions
  function automatic logic rwd_hit(input logic [9:0] idx);
    rwd_hit = (idx >= IDX_MODE) && (idx <= IDX_CNT_STAT);
  endfunction
endpackage

//--- pkg/rwd_regbus_if.sv
`timescale 1ns/10ps
// Register strobes between the bus slave and the watchdog core
interface rwd_regbus_if;
  logic        wrStb;
  logic [9:0]  wrIdx;
  logic [7:0]  wrData;
  logic [9:0]  rdIdx;
  logic [31:0] rdData;

  modport axil (
    output wrStb, wrIdx, wrData, rdIdx,
    input  rdData
  );
  modport core (
    input  wrStb, wrIdx, wrData, rdIdx,
    output rdData
  );
endinterface

//--- tb/rwd_watchdog_top_asserts.sv
`timescale 1ns/10ps
// Port-level checks on the watchdog top
module rwd_watchdog_top_asserts (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic [1:0] bresp,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic       watchdogNmi,
  input wire logic       wdtResetReq
);
  logic [4:0] rstLen_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Length of the running reset request; wraps if it sticks, so the cap below catches it
  always_ff @(posedge mclk) begin
    rstLen_ff <= (srst || !wdtResetReq) ? 5'h0 : rstLen_ff + 5'h1;
  end

  AST_NMI_PULSE: assert property (watchdogNmi |=> !watchdogNmi)
    else $error("nmi wider than one cycle");
  AST_RST_CAUSE: assert property ($rose(wdtResetReq) |-> $past(watchdogNmi))
    else $error("reset request without expiry");
  AST_RST_LEN: assert property ($fell(wdtResetReq) |-> rstLen_ff == 5'h16)
    else $error("reset request length wrong");
  AST_RST_MAX: assert property (wdtResetReq |-> rstLen_ff < 5'h16)
    else $error("reset request too long");
  AST_WR_ANS: assert property (awvalid && awready && wvalid && wready
    |=> !awready && !wready ##1 bvalid)
    else $error("write answer late");
  AST_WR_DONE: assert property (bvalid && bready |=> !bvalid && awready)
    else $error("write slot not freed");
  AST_RD_ANS: assert property (arvalid && arready |=> !arready ##1 rvalid)
    else $error("read answer late");
  AST_RD_DONE: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read slot not freed");

  CV_NMI: cover property (watchdogNmi);
  CV_RST: cover property ($rose(wdtResetReq));
  CV_ERR: cover property (bvalid && bresp == 2'h2);
endmodule

bind rwd_watchdog_top rwd_watchdog_top_asserts u_chk (
  .mclk(mclk), .srst(srst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .watchdogNmi(watchdogNmi),
  .wdtResetReq(wdtResetReq)
);

//--- tb/rwd_watchdog_top_test.sv
`timescale 1ns/10ps
module rwd_watchdog_top_test;
  logic        mclk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic        lightSleepOne, lightSleepTwo, stopMode;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        watchdogNmi, wdtResetReq, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, w;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          errTotal, samplesChecked, cyc, n;

  rwd_watchdog_top i_dut (
    .mclk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .lightSleepOne, .lightSleepTwo, .stopMode, .watchdogNmi, .wdtResetReq, .irq
  );

  // 40 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic testDone();
    $display("checks %0d errors %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard: one expiry period plus bus traffic fits well inside
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errTotal++;
      testDone();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      errTotal++;
    end
  endtask

  // Bus write; bready stays high, so the response edge ends the task.
  // Handshakes are judged mid-cycle, where the outputs have settled.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic awTaken;
    logic wTaken;
    logic done;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(negedge mclk);
      awTaken = awvalid && awready;
      wTaken = wvalid && wready;
      done = bvalid;
      rs = bresp;
      @(posedge mclk);
      if (awTaken) awvalid <= 1'b0;
      if (wTaken) wvalid <= 1'b0;
      if (done) break;
    end
  endtask

  // Bus read; rready stays high
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic arTaken;
    logic done;
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(negedge mclk);
      arTaken = arvalid && arready;
      done = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge mclk);
      if (arTaken) arvalid <= 1'b0;
      if (done) break;
    end
  endtask

  // Main sequence
  initial begin
    {awvalid, wvalid, arvalid, lightSleepOne, lightSleepTwo, stopMode} = 6'h0;
    {srst, bready, rready} = 3'h7;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hf;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd(12'hc00, v, r); chk(v, 32'h80);
    rd(12'hc10, v, r); chk(v[25:24], 2'h3);
    wr(12'hc00, 32'hff, r); rd(12'hc00, v, r); chk(v, 32'he6);
    wr(12'hc00, 32'h80, r);
    // Unmapped place and the write-only command word
    wr(12'hc14, 32'h1, r); chk(r, 2'h2);
    rd(12'hc14, v, r); chk({r, v[29:0]}, 32'h80000000);
    rd(12'hc04, v, r); chk(v, 32'h0);
    repeat (50) @(posedge mclk);
    wr(12'hc04, 32'h4e, r); rd(12'hc10, v, r); chk(v[21:0] < 22'h8, 1);
    // Foreign code, and disable code while still enabled, must not clear or stop
    foreach (w[i]) if (i < 2) begin
      rd(12'hc10, v, r);
      wr(12'hc04, i ? 32'hb1 : 32'h55, r);
      rd(12'hc10, w, r); chk({w[24], w[21:0] > v[21:0]}, 2'h3);
    end
    wr(12'hc00, 32'h0, r); wr(12'hc04, 32'hb1, r);
    rd(12'hc10, v, r); repeat (20) @(posedge mclk);
    rd(12'hc10, w, r); chk(w, v); chk(w[24], 0);
    wr(12'hc00, 32'h80, r); rd(12'hc10, v, r); repeat (20) @(posedge mclk);
    rd(12'hc10, w, r); chk(w[21:0] - v[21:0] > 22'd20, 1);
    // Each low-power mode without the sleep-two run bit freezes the count
    for (int i = 0; i < 3; i++) begin
      {stopMode, lightSleepOne, lightSleepTwo} <= 3'h1 << i;
      rd(12'hc10, v, r); repeat (10) @(posedge mclk);
      rd(12'hc10, w, r); chk(w[21:0], v[21:0]);
    end
    // Back to sleep two alone, now with the run bit set
    {stopMode, lightSleepOne, lightSleepTwo} <= 3'h1;
    wr(12'hc00, 32'h84, r); rd(12'hc10, v, r); repeat (10) @(posedge mclk);
    rd(12'hc10, w, r); chk(w[21:0] > v[21:0], 1);
    lightSleepTwo <= 1'b0;
    // Expiry at period 00 with reset routing, interrupt unmasked nowhere
    wr(12'hc00, 32'h82, r); wr(12'hc04, 32'h4e, r);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (watchdogNmi !== 1'b1);
    chk(n > 32763 && n < 32773, 1); chk(irq, 0);
    n = 0;
    @(negedge mclk);
    while (wdtResetReq === 1'b1) begin
      n++;
      @(negedge mclk);
    end
    chk(n, rwd_pkg::RST_STATES);
    rd(12'hc08, v, r); chk(v, 32'h3);
    wr(12'hc0c, 32'h3, r); repeat (2) @(posedge mclk); chk(irq, 1);
    wr(12'hc08, 32'h3, r); repeat (2) @(posedge mclk); chk(irq, 0);
    rd(12'hc08, v, r); chk(v, 32'h0);
    testDone();
  end
endmodule

//--- verilog/rwd_axil_slave.sv
`timescale 1ns/10ps
// AXI4-Lite slave: one write and one read in flight, byte data in lane 0
module rwd_axil_slave (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  rwd_regbus_if.axil       rb
);
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic [9:0]  wrIdx;
    logic [7:0]  wrData;
    logic        wrEn;
    logic        wrStb;
    logic        arready;
    logic        rPend;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [9:0]  rdIdx;
  } rwd_axs_t;

  rwd_axs_t state_ff;
  rwd_axs_t nxt_state;

  // Address and data are taken in either order; response after both
  always_comb begin
    nxt_state = state_ff;
    nxt_state.wrStb = 1'b0;
    if (awvalid && state_ff.awready) begin
      nxt_state.wrIdx   = awaddr[11:2];
      nxt_state.awready = 1'b0;
    end
    if (wvalid && state_ff.wready) begin
      nxt_state.wrData = wdata[7:0];
      nxt_state.wrEn   = wstrb[0];
      nxt_state.wready = 1'b0;
    end
    if (!state_ff.awready && !state_ff.wready && !state_ff.bvalid) begin
      nxt_state.wrStb  = state_ff.wrEn && rwd_pkg::rwd_hit(state_ff.wrIdx);
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = rwd_pkg::rwd_hit(state_ff.wrIdx) ? rwd_pkg::RESP_OKAY
                                                          : rwd_pkg::RESP_SLVERR;
    end
    if (state_ff.bvalid && bready) begin
      nxt_state.bvalid  = 1'b0;
      nxt_state.awready = 1'b1;
      nxt_state.wready  = 1'b1;
    end
    // Reads have no side effects, so data is sampled a cycle after the address
    if (arvalid && state_ff.arready) begin
      nxt_state.rdIdx   = araddr[11:2];
      nxt_state.arready = 1'b0;
      nxt_state.rPend   = 1'b1;
    end
    if (state_ff.rPend) begin
      nxt_state.rPend  = 1'b0;
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata  = rwd_pkg::rwd_hit(state_ff.rdIdx) ? rb.rdData : 32'h0;
      nxt_state.rresp  = rwd_pkg::rwd_hit(state_ff.rdIdx) ? rwd_pkg::RESP_OKAY
                                                          : rwd_pkg::RESP_SLVERR;
    end
    if (state_ff.rvalid && rready) begin
      nxt_state.rvalid  = 1'b0;
      nxt_state.arready = 1'b1;
    end
  end

  // Ready flags come up one cycle after reset release
  always_ff @(posedge mclk) begin
    if (srst) state_ff <= '0;
    else if (state_ff == '0) state_ff <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                           default: '0};
    else state_ff <= nxt_state;
  end

  assign awready   = state_ff.awready;
  assign wready    = state_ff.wready;
  assign bvalid    = state_ff.bvalid;
  assign bresp     = state_ff.bresp;
  assign arready   = state_ff.arready;
  assign rvalid    = state_ff.rvalid;
  assign rresp     = state_ff.rresp;
  assign rdata     = state_ff.rdata;
  assign rb.wrStb  = state_ff.wrStb;
  assign rb.wrIdx  = state_ff.wrIdx;
  assign rb.wrData = state_ff.wrData;
  assign rb.rdIdx  = state_ff.rdIdx;
endmodule

//--- verilog/rwd_reset_stretch.sv
`timescale 1ns/10ps
// Holds the internal reset request for a fixed number of states
module rwd_reset_stretch (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic trig,
  output logic      rstOut
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       out;
  } rwd_str_t;

  rwd_str_t state_ff;
  rwd_str_t nxt_state;

  // A new trigger while busy restarts the full length
  always_comb begin
    nxt_state = state_ff;
    if (trig) begin
      nxt_state.cnt = rwd_pkg::RST_STATES;
      nxt_state.out = 1'b1;
    end else if (state_ff.cnt != 5'h0) begin
      nxt_state.cnt = state_ff.cnt - 5'h1;
      nxt_state.out = (state_ff.cnt != 5'h1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) state_ff <= '0;
    else state_ff <= nxt_state;
  end

  assign rstOut = state_ff.out;
endmodule

//--- verilog/rwd_watchdog_top.sv
`timescale 1ns/10ps
// Contract
// - Counter is 22 binary stages on system clock
// - Period select 00..11 gives 2^15..2^21 cycles
// - Expiry at selected tap raises watchdog interrupt
// - Expiry interrupt cannot be masked
// - Command 4E clears counter, counting resumes
// - Command B1 disables only when enable bit 0
// - Writing enable bit 1 re-enables watchdog
// - After reset enabled, counting, period 00
// - No counting in light sleep one or stop
// - Light sleep two counts only with run bit
// - Reset route bit makes expiry request reset
// - Watchdog reset lasts 22 to 29 states
// - System clock after reset is prescaled half (not done here; the surrounding clock unit owns it)
module rwd_watchdog_top (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        lightSleepOne,
  input  wire logic        lightSleepTwo,
  input  wire logic        stopMode,
  output logic             watchdogNmi,
  output logic             wdtResetReq,
  output logic             irq
);
  typedef struct packed {
    logic [rwd_pkg::CNT_W-1:0] cnt;
    logic                      active;
    logic                      enBit;
    logic [1:0]                perSel;
    logic                      idle2Run;
    logic                      rstRoute;
    logic [1:0]                irqStat;
    logic [1:0]                irqMask;
    logic                      nmi;
    logic                      rstTrig;
    logic                      irq;
  } rwd_core_t;

  rwd_core_t core_ff;
  rwd_core_t nxt_core;

  rwd_regbus_if rb ();

  logic counting;
  logic expire;
  logic modeWr;
  logic cmdWr;
  logic statWr;
  logic maskWr;

  // Bus slave; register strobes come back through the interface
  rwd_axil_slave u_axil (
    .mclk    (mclk),
    .srst    (srst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rb      (rb.axil)
  );

  // Stretches the one-cycle trigger into the internal reset request
  rwd_reset_stretch u_stretch (
    .mclk   (mclk),
    .srst   (srst),
    .trig   (core_ff.rstTrig),
    .rstOut (wdtResetReq)
  );

  // True when the low stages selected by the period field are all ones,
  // so the next count carries out of the chosen tap
  function automatic logic rwd_tap_full(input logic [rwd_pkg::CNT_W-1:0] c,
                                        input logic [1:0]                sel);
    case (sel)
      2'h0:    rwd_tap_full = &c[14:0];
      2'h1:    rwd_tap_full = &c[16:0];
      2'h2:    rwd_tap_full = &c[18:0];
      2'h3:    rwd_tap_full = &c[20:0];
      default: rwd_tap_full = 1'b0;
    endcase
  endfunction

  // Mode register image; unused bits and the must-be-zero bit read as zero
  function automatic logic [7:0] rwd_mode_img(input rwd_core_t s);
    logic [7:0] m;
    m = 8'h0;
    m[rwd_pkg::MODE_EN_BIT]                        = s.enBit;
    m[rwd_pkg::MODE_PER_LSB+1:rwd_pkg::MODE_PER_LSB] = s.perSel;
    m[rwd_pkg::MODE_I2_BIT]                        = s.idle2Run;
    m[rwd_pkg::MODE_RST_BIT]                       = s.rstRoute;
    rwd_mode_img = m;
  endfunction

  // Write decode from the bus slave strobe
  assign modeWr = rb.wrStb && (rb.wrIdx == rwd_pkg::IDX_MODE);
  assign cmdWr  = rb.wrStb && (rb.wrIdx == rwd_pkg::IDX_CMD);
  assign statWr = rb.wrStb && (rb.wrIdx == rwd_pkg::IDX_IRQ_STAT);
  assign maskWr = rb.wrStb && (rb.wrIdx == rwd_pkg::IDX_IRQ_MASK);

  // Low-power inputs come from the power controller on mclk, so no sync.
  // mclk is the system clock: one state per edge, and after any reset the
  // clock gear delivers prescaled/2, which the surrounding clock unit owns.
  assign counting = core_ff.active && !lightSleepOne && !stopMode
                    && (!lightSleepTwo || core_ff.idle2Run);
  assign expire   = counting && rwd_tap_full(core_ff.cnt, core_ff.perSel);

  // Read mux; the command register is write-only and reads as zero
  always_comb begin
    rb.rdData = 32'h0;
    case (rb.rdIdx)
      rwd_pkg::IDX_MODE:     rb.rdData[7:0] = rwd_mode_img(core_ff);
      rwd_pkg::IDX_IRQ_STAT: rb.rdData[1:0] = core_ff.irqStat;
      rwd_pkg::IDX_IRQ_MASK: rb.rdData[1:0] = core_ff.irqMask;
      rwd_pkg::IDX_CNT_STAT: begin
        rb.rdData[rwd_pkg::CNT_W-1:0]     = core_ff.cnt;
        rb.rdData[rwd_pkg::CST_ACTIVE]   = core_ff.active;
        rb.rdData[rwd_pkg::CST_COUNTING] = counting;
      end
      default:               rb.rdData = 32'h0;
    endcase
  end

  // Next-state logic for the whole watchdog
  always_comb begin
    nxt_core = core_ff;
    nxt_core.nmi     = 1'b0;
    nxt_core.rstTrig = 1'b0;

    // Counting and expiry; the counter restarts so a stuck CPU sees
    // a fresh interrupt every period rather than a single one
    if (expire) begin
      nxt_core.cnt = '0;
      nxt_core.nmi = 1'b1;
      nxt_core.rstTrig = core_ff.rstRoute;
    end else if (counting) begin
      nxt_core.cnt = core_ff.cnt + 22'h1;
    end

    // Mode register write; bit 0 is ignored
    if (modeWr) begin
      nxt_core.enBit    = rb.wrData[rwd_pkg::MODE_EN_BIT];
      nxt_core.perSel   = rb.wrData[rwd_pkg::MODE_PER_LSB+1:rwd_pkg::MODE_PER_LSB];
      nxt_core.idle2Run = rb.wrData[rwd_pkg::MODE_I2_BIT];
      nxt_core.rstRoute = rb.wrData[rwd_pkg::MODE_RST_BIT];
      if (rb.wrData[rwd_pkg::MODE_EN_BIT]) begin
        nxt_core.active = 1'b1;
      end
    end

    // Command register: only the two codes act, anything else is dropped.
    // Disable needs the enable bit already low, which makes a runaway
    // program unlikely to switch the watchdog off by accident.
    if (cmdWr) begin
      case (rb.wrData)
        rwd_pkg::CMD_CLEAR:   nxt_core.cnt = '0;
        rwd_pkg::CMD_DISABLE: begin
          if (!core_ff.enBit) begin
            nxt_core.active = 1'b0;
          end
        end
        default:              nxt_core.active = core_ff.active;
      endcase
    end

    // Mask register
    if (maskWr) begin
      nxt_core.irqMask = rb.wrData[1:0];
    end

    // Sticky status: write one to clear, a same-cycle event wins
    if (statWr) begin
      nxt_core.irqStat = core_ff.irqStat & ~rb.wrData[1:0];
    end
    if (expire) begin
      nxt_core.irqStat[rwd_pkg::IRQ_EXPIRE] = 1'b1;
    end
    if (expire && core_ff.rstRoute) begin
      nxt_core.irqStat[rwd_pkg::IRQ_WRESET] = 1'b1;
    end

    // Level interrupt registered from next-state status and mask
    nxt_core.irq = |(nxt_core.irqStat & nxt_core.irqMask);
  end

  // Reset leaves the watchdog enabled and counting at the shortest period
  always_ff @(posedge mclk) begin
    if (srst) begin
      core_ff        <= '0;
      core_ff.active <= rwd_pkg::EN_RESET;
      core_ff.enBit  <= rwd_pkg::EN_RESET;
      core_ff.perSel <= rwd_pkg::PER_RESET;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // The stretch module holds the request for a fixed count of states
  // inside the allowed window, so a late gear change cannot shorten it
  assign watchdogNmi = core_ff.nmi;
  assign irq         = core_ff.irq;
endmodule
